/* ast_pkg.sv */
// Shared constants and carrier types for the converter sample timing block.
// Assumes a 100 MHz mclk domain and a 32-bit classic Wishbone register port.
package ast_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int AST_TIME_W = 13; // Precharge / acquisition setting width
  localparam int AST_RES_W = 12; // Conversion result width
  localparam int AST_ACC_W = 18; // Accumulator width
  localparam int AST_ADR_W = 8; // Wishbone byte address width
  // ----------------------------------------------------------------
  // Register byte offsets (one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] AST_OFS_CTRL = 8'h00;
  localparam logic [7:0] AST_OFS_CLKDIV = 8'h04;
  localparam logic [7:0] AST_OFS_PRE_L = 8'h08;
  localparam logic [7:0] AST_OFS_PRE_H = 8'h0C;
  localparam logic [7:0] AST_OFS_ACQ_L = 8'h10;
  localparam logic [7:0] AST_OFS_ACQ_H = 8'h14;
  localparam logic [7:0] AST_OFS_CAP = 8'h18;
  localparam logic [7:0] AST_OFS_RPT = 8'h1C;
  localparam logic [7:0] AST_OFS_CNT = 8'h20;
  localparam logic [7:0] AST_OFS_FLT_H = 8'h24;
  localparam logic [7:0] AST_OFS_FLT_L = 8'h28;
  localparam logic [7:0] AST_OFS_RES_H = 8'h2C;
  localparam logic [7:0] AST_OFS_RES_L = 8'h30;
  localparam logic [7:0] AST_OFS_STATUS = 8'h34;
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int AST_CTRL_SRC = 0; // conversion_clock_source_bit
  localparam int AST_CTRL_FMT = 1; // result_justify_select
  localparam int AST_CTRL_MODE_LO = 2; // Computation mode, 3 bits
  localparam int AST_CTRL_CRS_LO = 5; // computation_right_shift, 3 bits
  localparam logic [7:0] AST_CTRL_RST = 8'h00;
  // Computation mode codes
  localparam logic [2:0] AST_MODE_BASIC = 3'h0;
  localparam logic [2:0] AST_MODE_ACC = 3'h1;
  localparam logic [2:0] AST_MODE_AVG = 3'h2;
  localparam logic [2:0] AST_MODE_BAVG = 3'h3;
  localparam logic [2:0] AST_MODE_LPF = 3'h4;
  // Stage status codes
  localparam logic [2:0] AST_STAT_IDLE = 3'h0;
  localparam logic [2:0] AST_STAT_PRE = 3'h1;
  localparam logic [2:0] AST_STAT_ACQ = 3'h2;
  localparam logic [2:0] AST_STAT_CONV = 3'h3;
  // Acquisition length used when its setting is zero after a precharge
  localparam logic [13:0] AST_ACQ_FULL = 14'h2000;
  localparam logic [7:0] AST_BYTE_RST = 8'h00;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {AST_S_IDLE, AST_S_PRE, AST_S_ACQ, AST_S_CONV} ast_stage_t;
  typedef struct packed {
    logic done; // Conversion finished, result valid
    logic [AST_RES_W-1:0] res; // Conversion result
  } ast_conv_t;
  typedef struct packed {
    logic vld; // Accumulator / filter update strobe
    logic [AST_ACC_W-1:0] acc; // accumulator_value, signed
    logic [15:0] low_pass_filter_mode; // Low-pass filter result, signed
  } ast_comp_t;
endpackage : ast_pkg

/* ast_timing.sv */
// Sample timing, trigger repeat counting, filter output and result registers.
// Assumes trigger, conversion and computation inputs come from mclk logic;
// the dedicated RC clock arrives asynchronously and is sampled here.
// Functional notes
// - Nonzero setting N lasts N selected clocks
// - Zero precharge setting skips precharge stage
// - Zero acquisition: skip, or 8192 after precharge
// - Acquisition high register bits 7..5 read zero
// - Capacitor field adds n pF, upper bits zero
// - Repeat threshold gates check in filter modes
// - Writable trigger counter increments per trigger
// - Filter output is accumulator shifted right arithmetically
// - Low-pass mode shows low-pass filter result
// - Filter output read-only signed, two bytes
// - Left-justified upper result holds bits 11..4
// - Source bit zero selects system clock, divider
// - Stages precharge, acquisition, conversion; status code
// - Left-justified lower result holds bits 3..0
`timescale 1ns/10ps
module ast_timing
  import ast_pkg::*;
#(
  parameter int TIME_W = AST_TIME_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AST_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Converter side
  input wire logic rc_clk_pin,
  input wire logic trig_i,
  input wire ast_conv_t conv_i,
  input wire ast_comp_t comp_i,
  output logic [2:0] stage_o,
  output logic [4:0] cap_sel_o,
  output logic conv_tick_o,
  output logic chk_o
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (TIME_W != AST_TIME_W) begin : g_bad_width
    $error("TIME_W must equal the 13-bit setting width");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q; // Source, format, mode, shift
  logic [5:0] clkdiv_q; // System clock divider select
  logic [TIME_W-1:0] pre_q; // precharge_time_setting
  logic [TIME_W-1:0] acq_q; // acquisition_time_setting
  logic [4:0] cap_q; // extra_capacitance_field
  logic [7:0] rpt_q; // repeat_threshold_field
  logic [7:0] cnt_q; // trigger_count_field
  logic [15:0] filter_output_value_q; // filter_output_value
  logic [7:0] resh_q; // Upper result register
  logic [7:0] resl_q; // Lower result register
  ast_stage_t stg_q; // Current stage
  ast_stage_t stg_d; // Next stage
  logic [TIME_W:0] tcnt_q; // Remaining stage ticks
  logic [TIME_W:0] tcnt_d;
  logic [6:0] div_q; // Divider phase counter
  logic rc_s1_q; // Synchroniser first stage
  logic rc_s2_q; // Synchroniser second stage
  logic rc_s3_q; // Edge history
  logic ack_q;
  logic [31:0] rdat_q;

  // Decoded controls
  logic clk_src; // High selects the dedicated RC clock
  logic fmt_right; // High selects right-justified result
  logic [2:0] mode;
  logic [2:0] computation_right_shift;
  logic rc_tick;
  logic stg_tick;
  logic wr_en;
  logic [7:0] wbyte;
  logic [7:0] cnt_inc;
  logic rpt_mode;

  assign clk_src = ctrl_q[AST_CTRL_SRC];
  assign fmt_right = ctrl_q[AST_CTRL_FMT];
  assign mode = ctrl_q[AST_CTRL_MODE_LO +: 3];
  assign computation_right_shift = ctrl_q[AST_CTRL_CRS_LO +: 3];
  assign wbyte = wb_dat_i[7:0];
  // Write lands on the edge where the master samples ack
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
  assign cnt_inc = cnt_q + 8'h01;
  assign rpt_mode = (mode == AST_MODE_LPF) | (mode == AST_MODE_AVG) | (mode == AST_MODE_BAVG);

  // ----------------------------------------------------------------
  // RC clock sampling
  // ----------------------------------------------------------------
  // Two flops before use; third flop only for edge detect
  always_ff @(posedge mclk) begin
    if (srst) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end else begin
      rc_s1_q <= rc_clk_pin;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end

  // One tick per RC rising edge; the RC clock must stay below mclk / 2
  assign rc_tick = rc_s2_q & ~rc_s3_q;
  // Stage timing counts system clock or RC ticks
  assign stg_tick = clk_src ? rc_tick : 1'b1;

  // ----------------------------------------------------------------
  // Conversion clock divider
  // ----------------------------------------------------------------
  // Divider only applies with the system clock selected
  always_ff @(posedge mclk) begin
    if (srst) begin
      div_q <= 7'h00;
      conv_tick_o <= 1'b0;
    end else if (clk_src) begin
      div_q <= 7'h00;
      conv_tick_o <= rc_tick;
    end else if (div_q >= {clkdiv_q, 1'b1}) begin
      div_q <= 7'h00;
      conv_tick_o <= 1'b1;
    end else begin
      div_q <= div_q + 7'h01;
      conv_tick_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Stage sequencer
  // ----------------------------------------------------------------
  // Next stage and counter load; settings are read only at stage start
  always_comb begin
    stg_d = stg_q;
    tcnt_d = tcnt_q;
    unique case (stg_q)
      AST_S_IDLE: begin
        if (trig_i) begin
          if (pre_q != '0) begin
            stg_d = AST_S_PRE;
            tcnt_d = {1'b0, pre_q};
          end else if (acq_q != '0) begin
            stg_d = AST_S_ACQ;
            tcnt_d = {1'b0, acq_q};
          end else begin
            stg_d = AST_S_CONV;
          end
        end
      end
      AST_S_PRE: begin
        if (stg_tick) begin
          tcnt_d = tcnt_q - 14'h0001;
          if (tcnt_q == 14'h0001) begin
            stg_d = AST_S_ACQ;
            tcnt_d = (acq_q == '0) ? AST_ACQ_FULL : {1'b0, acq_q};
          end
        end
      end
      AST_S_ACQ: begin
        if (stg_tick) begin
          tcnt_d = tcnt_q - 14'h0001;
          if (tcnt_q == 14'h0001) begin
            stg_d = AST_S_CONV;
          end
        end
      end
      AST_S_CONV: begin
        // Conversion length is set by the converter core
        if (conv_i.done) begin
          stg_d = AST_S_IDLE;
        end
      end
    endcase
  end

  // Stage state and counter
  always_ff @(posedge mclk) begin
    if (srst) begin
      stg_q <= AST_S_IDLE;
      tcnt_q <= '0;
    end else begin
      stg_q <= stg_d;
      tcnt_q <= tcnt_d;
    end
  end

  // Stage status code, registered for the output
  always_ff @(posedge mclk) begin
    if (srst) begin
      stage_o <= AST_STAT_IDLE;
    end else begin
      unique case (stg_d)
        AST_S_IDLE: stage_o <= AST_STAT_IDLE;
        AST_S_PRE: stage_o <= AST_STAT_PRE;
        AST_S_ACQ: stage_o <= AST_STAT_ACQ;
        AST_S_CONV: stage_o <= AST_STAT_CONV;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software-written settings
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q <= AST_CTRL_RST;
      clkdiv_q <= '0;
      pre_q <= '0;
      acq_q <= '0;
      cap_q <= '0;
      rpt_q <= AST_BYTE_RST;
    end else if (wr_en) begin
      unique case (wb_adr_i)
        AST_OFS_CTRL: ctrl_q <= wbyte;
        AST_OFS_CLKDIV: clkdiv_q <= wbyte[5:0];
        AST_OFS_PRE_L: pre_q[7:0] <= wbyte;
        AST_OFS_PRE_H: pre_q[TIME_W-1:8] <= wbyte[4:0];
        AST_OFS_ACQ_L: acq_q[7:0] <= wbyte;
        AST_OFS_ACQ_H: acq_q[TIME_W-1:8] <= wbyte[4:0];
        AST_OFS_CAP: cap_q <= wbyte[4:0];
        AST_OFS_RPT: rpt_q <= wbyte;
        default: ;
      endcase
    end
  end

  // Capacitor select drives n unit 1 pF cells, zero adds none
  always_ff @(posedge mclk) begin
    if (srst) begin
      cap_sel_o <= '0;
    end else begin
      cap_sel_o <= cap_q;
    end
  end

  // ----------------------------------------------------------------
  // Trigger counter and threshold check
  // ----------------------------------------------------------------
  // A write and a trigger together: the written value is incremented
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q <= AST_BYTE_RST;
    end else if (wr_en && wb_adr_i == AST_OFS_CNT) begin
      cnt_q <= trig_i ? wbyte + 8'h01 : wbyte;
    end else if (trig_i) begin
      cnt_q <= cnt_inc;
    end
  end

  // Check pulse once the repeat threshold is reached, in averaging and low-pass modes only
  always_ff @(posedge mclk) begin
    if (srst) begin
      chk_o <= 1'b0;
    end else begin
      chk_o <= trig_i & rpt_mode & (cnt_inc >= rpt_q);
    end
  end

  // ----------------------------------------------------------------
  // Filter output and results
  // ----------------------------------------------------------------
  // Filter is read-only; updated by the computation strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      filter_output_value_q <= '0;
    end else if (comp_i.vld) begin
      if (mode == AST_MODE_LPF) begin
        filter_output_value_q <= comp_i.low_pass_filter_mode;
      end else begin
        filter_output_value_q <= 16'($signed(comp_i.acc) >>> computation_right_shift);
      end
    end
  end

  // Hardware result load wins over a same-cycle software write
  always_ff @(posedge mclk) begin
    if (srst) begin
      resh_q <= AST_BYTE_RST;
      resl_q <= AST_BYTE_RST;
    end else if (conv_i.done && stg_q == AST_S_CONV) begin
      if (fmt_right) begin
        resh_q <= {4'h0, conv_i.res[11:8]};
        resl_q <= conv_i.res[7:0];
      end else begin
        resh_q <= conv_i.res[11:4];
        resl_q <= {conv_i.res[3:0], 4'h0};
      end
    end else if (wr_en && wb_adr_i == AST_OFS_RES_H) begin
      resh_q <= wbyte;
    end else if (wr_en && wb_adr_i == AST_OFS_RES_L) begin
      resl_q <= wbyte;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone answer
  // ----------------------------------------------------------------
  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      unique case (wb_adr_i)
        AST_OFS_CTRL: rdat_q <= {24'h0, ctrl_q};
        AST_OFS_CLKDIV: rdat_q <= {26'h0, clkdiv_q};
        AST_OFS_PRE_L: rdat_q <= {24'h0, pre_q[7:0]};
        AST_OFS_PRE_H: rdat_q <= {27'h0, pre_q[TIME_W-1:8]};
        AST_OFS_ACQ_L: rdat_q <= {24'h0, acq_q[7:0]};
        AST_OFS_ACQ_H: rdat_q <= {27'h0, acq_q[TIME_W-1:8]};
        AST_OFS_CAP: rdat_q <= {27'h0, cap_q};
        AST_OFS_RPT: rdat_q <= {24'h0, rpt_q};
        AST_OFS_CNT: rdat_q <= {24'h0, cnt_q};
        AST_OFS_FLT_H: rdat_q <= {24'h0, filter_output_value_q[15:8]};
        AST_OFS_FLT_L: rdat_q <= {24'h0, filter_output_value_q[7:0]};
        AST_OFS_RES_H: rdat_q <= {24'h0, resh_q};
        AST_OFS_RES_L: rdat_q <= {24'h0, resl_q};
        AST_OFS_STATUS: rdat_q <= {29'h0, stage_o};
        default: rdat_q <= '0; // Unmapped reads as zero
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // Helper: ticks seen in the current stage and its loaded length
  logic [TIME_W:0] seen_q;
  logic [TIME_W:0] len_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      seen_q <= '0;
      len_q <= '0;
    end else if (stg_d != stg_q) begin
      seen_q <= '0;
      len_q <= tcnt_d;
    end else if (stg_tick) begin
      seen_q <= seen_q + 14'h0001;
    end
  end

  property p_stage_len;
    (stg_q inside {AST_S_PRE, AST_S_ACQ}) && stg_d != stg_q |-> seen_q + 14'h0001 == len_q;
  endproperty
  a_stage_len: assert property (p_stage_len) else $error("stage tick count wrong");

  property p_skip_pre;
    stg_q == AST_S_IDLE && trig_i && pre_q == '0 |=> stg_q != AST_S_PRE && stage_o != AST_STAT_PRE;
  endproperty
  a_skip_pre: assert property (p_skip_pre) else $error("precharge not skipped");

  property p_acq_full;
    stg_q == AST_S_PRE && stg_d == AST_S_ACQ && acq_q == '0 |=> tcnt_q == AST_ACQ_FULL;
  endproperty
  a_acq_full: assert property (p_acq_full) else $error("acquisition not 8192");

  property p_no_acq;
    stg_q == AST_S_IDLE && trig_i && pre_q == '0 && acq_q == '0 |=> stg_q == AST_S_CONV;
  endproperty
  a_no_acq: assert property (p_no_acq) else $error("zero stages not omitted");

  property p_acqh_read;
    wb_cyc_i && wb_stb_i && !ack_q && wb_adr_i == AST_OFS_ACQ_H
      |=> wb_ack_o && wb_dat_o[7:5] == 3'h0;
  endproperty
  a_acqh_read: assert property (p_acqh_read) else $error("acq high upper bits set");

  property p_cap;
    wr_en && wb_adr_i == AST_OFS_CAP |=> ##1 cap_sel_o == $past(wbyte[4:0], 2);
  endproperty
  a_cap: assert property (p_cap) else $error("capacitor select wrong");

  property p_chk;
    trig_i && !rpt_mode |=> !chk_o;
  endproperty
  a_chk: assert property (p_chk) else $error("check outside filter modes");

  property p_cnt;
    trig_i && !(wr_en && wb_adr_i == AST_OFS_CNT) |=> cnt_q == $past(cnt_q) + 8'h01;
  endproperty
  a_cnt: assert property (p_cnt) else $error("trigger count not advanced");

  property p_filter_output_value;
    comp_i.vld && mode != AST_MODE_LPF
      |=> filter_output_value_q == 16'($signed($past(comp_i.acc)) >>> $past(computation_right_shift));
  endproperty
  a_filter_output_value: assert property (p_filter_output_value) else $error("shifted accumulator wrong");

  property p_lpf;
    comp_i.vld && mode == AST_MODE_LPF |=> filter_output_value_q == $past(comp_i.low_pass_filter_mode);
  endproperty
  a_lpf: assert property (p_lpf) else $error("low-pass output wrong");

  property p_left;
    conv_i.done && stg_q == AST_S_CONV && !fmt_right |=> resh_q == $past(conv_i.res[11:4])
      && resl_q[7:4] == $past(conv_i.res[3:0]);
  endproperty
  a_left: assert property (p_left) else $error("left-justified result wrong");

  property p_order;
    stg_q == AST_S_PRE |=> stg_q inside {AST_S_PRE, AST_S_ACQ};
  endproperty
  a_order: assert property (p_order) else $error("stage order broken");

  c_full_sample: cover property (stg_q == AST_S_ACQ ##[1:300] stg_q == AST_S_IDLE);
  c_rc_pre: cover property (clk_src && stg_q == AST_S_PRE && rc_tick);
  c_chk: cover property (chk_o);
  c_lpf: cover property (comp_i.vld && mode == AST_MODE_LPF);

endmodule : ast_timing

/* tb_adc_sample_timing_and_filter_regs.sv */
// Self-checking bench for the converter sample timing and filter registers.
// Assumes ast_pkg and ast_timing are compiled first; one 100 MHz mclk domain.
`timescale 1ns/10ps
module tb_adc_sample_timing_and_filter_regs;
  import ast_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0; // System clock
  logic srst = 1'b1; // Held for three edges at start
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic rc_clk_pin = 1'b0; // Free-running slow clock
  logic trig_i = 1'b0;
  ast_conv_t conv_i = '0;
  ast_comp_t comp_i = '0;
  logic [2:0] stage_o;
  logic [4:0] cap_sel_o;
  logic conv_tick_o;
  logic chk_o;
  int bad_count = 0; // Mismatches
  int samples_checked = 0; // Comparisons made
  int ticks = 0; // Divider ticks seen in a window
  logic [31:0] rd; // Last read data
  logic [15:0] fexp; // Expected filter word
  // Register row: address, write value, reset value, read-back value
  typedef struct packed {
    logic [7:0] adr;
    logic [7:0] wr;
    logic [7:0] rst;
    logic [7:0] rdv;
  } ast_row_t;
  ast_row_t rows [10];
  // ----------------------------------------------------------------
  // Device and clocks
  // ----------------------------------------------------------------
  ast_timing dut (
    .mclk(mclk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .rc_clk_pin(rc_clk_pin), .trig_i(trig_i), .conv_i(conv_i),
    .comp_i(comp_i), .stage_o(stage_o), .cap_sel_o(cap_sel_o),
    .conv_tick_o(conv_tick_o), .chk_o(chk_o)
  );
  initial begin
    forever #5 mclk = ~mclk;
  end
  // Half period 32 ns never lands on an mclk rising edge
  initial begin
    forever #32 rc_clk_pin = ~rc_clk_pin;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Verdict; the only place the run ends
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Classic single cycle; held until ack is sampled, released at that edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h00_0000, dat};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      close_out();
    end
  endtask : wb
  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
    wb(1'b0, adr, 8'h00);
    check(rd, {24'h00_0000, exp});
  endtask : rd_chk
  // One-cycle trigger; returns just after the edge that took it
  task automatic pulse_trig;
    @(posedge mclk);
    trig_i <= 1'b1;
    @(posedge mclk);
    trig_i <= 1'b0;
    #1;
  endtask : pulse_trig
  // Ends the conversion stage with a result and checks the return to idle
  task automatic end_conv(input logic [11:0] value);
    conv_i <= {1'b1, value};
    @(posedge mclk);
    conv_i <= '0;
    #1;
    check(stage_o, AST_STAT_IDLE);
  endtask : end_conv
  // Full sample: program both settings, count ticks spent in precharge and in acquisition
  task automatic run_sample(input logic [12:0] charge_set, input logic [12:0] share_set,
      input logic [7:0] ctrl, input int e_charge, input int e_share,
      input logic [11:0] value, input logic [7:0] hi, input logic [7:0] lo);
    int n_charge;
    int n_share;
    int n;
    logic [2:0] prev;
    logic tick;
    wb(1'b1, AST_OFS_CTRL, ctrl);
    wb(1'b1, AST_OFS_PRE_L, charge_set[7:0]);
    wb(1'b1, AST_OFS_PRE_H, {3'h0, charge_set[12:8]});
    wb(1'b1, AST_OFS_ACQ_L, share_set[7:0]);
    wb(1'b1, AST_OFS_ACQ_H, {3'h0, share_set[12:8]});
    n_charge = 0;
    n_share = 0;
    n = 0;
    pulse_trig();
    prev = stage_o;
    // Bounded wait for conversion; a tick belongs to the stage held before its edge.
    // System clock: every mclk edge counts; RC source: conv_tick_o echoes the tick
    while (prev !== AST_STAT_CONV && n < 40000) begin
      @(posedge mclk);
      #1;
      n++;
      tick = ctrl[AST_CTRL_SRC] ? conv_tick_o : 1'b1;
      if (prev === AST_STAT_PRE && tick === 1'b1) begin
        n_charge++;
      end
      if (prev === AST_STAT_ACQ && tick === 1'b1) begin
        n_share++;
      end
      prev = stage_o;
    end
    if (n >= 40000) begin
      bad_count++;
      close_out();
    end
    check(n_charge, e_charge);
    check(n_share, e_share);
    rd_chk(AST_OFS_STATUS, {5'h00, AST_STAT_CONV});
    end_conv(value);
    rd_chk(AST_OFS_RES_H, hi);
    rd_chk(AST_OFS_RES_L, lo);
    $display("sample test %0d/%0d done", charge_set, share_set);
  endtask : run_sample
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = {AST_OFS_ACQ_L, 8'hff, 8'h00, 8'hff};
    rows[1] = {AST_OFS_ACQ_H, 8'hff, 8'h00, 8'h1f};
    rows[2] = {AST_OFS_CAP, 8'hff, 8'h00, 8'h1f};
    rows[3] = {AST_OFS_RPT, 8'ha5, 8'h00, 8'ha5};
    rows[4] = {AST_OFS_CNT, 8'h3c, 8'h00, 8'h3c};
    rows[5] = {AST_OFS_FLT_H, 8'hff, 8'h00, 8'h00};
    rows[6] = {AST_OFS_FLT_L, 8'hff, 8'h00, 8'h00};
    rows[7] = {AST_OFS_RES_H, 8'h5a, 8'h00, 8'h5a};
    rows[8] = {AST_OFS_STATUS, 8'hff, 8'h00, 8'h00};
    rows[9] = {8'h3c, 8'hff, 8'h00, 8'h00};
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    #1;
    // Every output except wb_dat_o idle straight after reset
    check({wb_ack_o, chk_o, conv_tick_o, cap_sel_o, stage_o}, 32'h0000_0000);
    // Reset value, write, read back for every row
    foreach (rows[i]) begin
      rd_chk(rows[i].adr, rows[i].rst);
      wb(1'b1, rows[i].adr, rows[i].wr);
      rd_chk(rows[i].adr, rows[i].rdv);
    end
    $display("register table test done");
    // Capacitor selection reaches the analog side unchanged
    wb(1'b1, AST_OFS_CAP, 8'h05);
    repeat (2) @(posedge mclk);
    #1;
    check(cap_sel_o, 5'h05);
    $display("capacitor test done");
    // Stage lengths, both clock sources, divider and both formats
    run_sample(13'h0003, 13'h0002, 8'h00, 3, 2, 12'habc, 8'hab, 8'hc0);
    run_sample(13'h0000, 13'h0002, 8'h02, 0, 2, 12'h5a3, 8'h05, 8'ha3);
    run_sample(13'h0001, 13'h0000, 8'h00, 1, 8192, 12'h123, 8'h12, 8'h30);
    run_sample(13'h0002, 13'h0003, 8'h01, 2, 3, 12'hfed, 8'hfe, 8'hd0);
    // System clock divided by 2*(3+1): four ticks in any 32 edges
    wb(1'b1, AST_OFS_CTRL, 8'h00);
    wb(1'b1, AST_OFS_CLKDIV, 8'h03);
    repeat (32) begin
      @(posedge mclk);
      #1;
      if (conv_tick_o === 1'b1) begin
        ticks++;
      end
    end
    check(ticks, 4);
    run_sample(13'h0004, 13'h0001, 8'h00, 4, 1, 12'h00f, 8'h00, 8'hf0);
    run_sample(13'h0000, 13'h0000, 8'h00, 0, 0, 12'h800, 8'h80, 8'h00);
    // Repeat threshold of two in every mode; sample parks in conversion
    for (int m = 0; m <= 4; m++) begin
      wb(1'b1, AST_OFS_CTRL, {3'h0, m[2:0], 2'b00});
      wb(1'b1, AST_OFS_RPT, 8'h02);
      wb(1'b1, AST_OFS_CNT, 8'h00);
      pulse_trig();
      check(chk_o, 1'b0);
      pulse_trig();
      check(chk_o, m >= 2);
      rd_chk(AST_OFS_CNT, 8'h02);
      end_conv(12'h000);
    end
    $display("repeat threshold test done");
    // Filter output in each computation mode except basic, shift of three
    for (int m = 1; m <= 4; m++) begin
      wb(1'b1, AST_OFS_CTRL, {3'h3, m[2:0], 2'b00});
      @(posedge mclk);
      comp_i <= {1'b1, 18'h3_fc18, 16'h1234};
      @(posedge mclk);
      comp_i <= '0;
      // -1000 shifted right by three is -125
      fexp = (m == 4) ? 16'h1234 : 16'hff83;
      rd_chk(AST_OFS_FLT_H, fexp[15:8]);
      rd_chk(AST_OFS_FLT_L, fexp[7:0]);
    end
    $display("filter test done");
    // Second reset in mid-run clears settings and status
    wb(1'b1, AST_OFS_RPT, 8'h77);
    // Park a sample in conversion so the reset must abort it
    pulse_trig();
    check(stage_o, AST_STAT_CONV);
    @(posedge mclk);
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rd_chk(AST_OFS_RPT, 8'h00);
    check(stage_o, AST_STAT_IDLE);
    check(cap_sel_o, 5'h00);
    $display("reset test done");
    close_out();
  end
endmodule : tb_adc_sample_timing_and_filter_regs
